//--- design/iet_params.svh
// Offsets, field positions, reset values and cycle counts of the interrupt block.
// Assumes a 32-bit classic Wishbone register port, word addressed by adr_i[9:2].
`ifndef IET_PARAMS_SVH
`define IET_PARAMS_SVH

// Word indices of the register map
`define IET_IDX_NODE0 8'h00
`define IET_IDX_SRCSEL 8'h40
`define IET_IDX_TRAPFLAG 8'h41
`define IET_IDX_EDGECFG 8'h42
`define IET_IDX_GATECFG 8'h43
`define IET_IDX_PATTERN 8'h44
`define IET_IDX_CHAN0 8'h48

// Node control fields
`define IET_NODE_PRIO_LSB 0
`define IET_NODE_EN_BIT 4
`define IET_NODE_REQ_BIT 5
`define IET_NODE_XFER_BIT 6
`define IET_NODE_CHAN_LSB 7
`define IET_NODE_RESET 10'h000

// Transfer channel control word fields
`define IET_CH_WORD_BIT 8
`define IET_CH_INCSRC_BIT 9
`define IET_CH_INCDST_BIT 10
`define IET_CH_CONT_BIT 11

// Trap flag bits above the hardware trap inputs
`define IET_TRAP_SR0_BIT 8
`define IET_TRAP_SR1_BIT 9
`define IET_TRAP_ESR2_BIT 10

// Vector base for traps and response latencies in CPU clocks
`define IET_TRAP_VEC_BASE 8'h80
`define IET_LAT_CACHE 7
`define IET_LAT_NOCACHE 11

`endif

//--- design/iet_pkg.sv
// Types shared by the interrupt and event transfer block.
// Assumes iet_params.svh supplies the numeric constants.
package iet_pkg;

  // Service sequencer states, one-hot
  typedef enum logic [2:0] {
    IET_ST_IDLE = 3'b001,
    IET_ST_WAIT = 3'b010,
    IET_ST_STEAL = 3'b100
  } iet_state_type;

  // Gate unit filter modes
  typedef enum logic [1:0] {
    IET_GATE_PASS = 2'b00,
    IET_GATE_MATCH = 2'b01,
    IET_GATE_MISS = 2'b10,
    IET_GATE_BLOCK = 2'b11
  } iet_gate_type;

endpackage

//--- design/iet_top.sv
// Interrupt nodes, arbiter, event transfer channels, external request router and traps.
// Assumes synchronous pulse inputs, a CPU that takes branch_o/vector_o and reports
// trap return on trap_ret_i, and a memory port that performs xfer_valid_o moves.
`timescale 1ns/10ps
`default_nettype none
`include "iet_params.svh"

module iet_top
  import iet_pkg::*;
#(
  parameter int NODES = 64,
  parameter int CHANS = 8,
  parameter int SHARED = 4,
  parameter int AW = 24
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Request sources
  input wire logic [NODES-1:0] src_i,
  input wire logic [SHARED-1:0] alt_src_i,
  input wire logic [3:0] ext_req_i,
  input wire logic [7:0] hw_trap_i,
  input wire logic [2:0] esr_pin_i,
  // CPU side
  input wire logic [3:0] cpu_level_i,
  input wire logic jump_cache_i,
  input wire logic sw_trap_i,
  input wire logic [7:0] sw_trap_num_i,
  input wire logic trap_ret_i,
  output logic branch_o,
  output logic [7:0] vector_o,
  output logic trap_busy_o,
  output logic cpu_stall_o,
  // Transfer memory port
  output logic xfer_valid_o,
  output logic [AW-1:0] xfer_src_o,
  output logic [AW-1:0] xfer_dst_o,
  output logic xfer_word_o
);

  localparam int CH_BASE = `IET_IDX_CHAN0;

  // Byte-lane merge for register writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Register state
  logic [9:0] node_cfg [NODES];
  logic [SHARED-1:0] src_sel;
  logic [10:0] trap_flag;
  logic [10:0] trap_taken;
  logic [7:0] edge_cfg;
  logic [31:0] gate_cfg;
  logic [15:0] pattern;
  logic [AW-1:0] ch_src [CHANS];
  logic [AW-1:0] ch_dst [CHANS];
  logic [11:0] ch_ctl [CHANS];
  iet_state_type state;
  logic [3:0] lat_cnt;
  logic [3:0] trap_prio;
  logic [2:0] act_chan;
  logic [3:0] ext_prev;
  logic [2:0] esr_prev;

  // Bus decode
  logic wr_en;
  logic [7:0] widx;
  assign wr_en = cyc_i && stb_i && we_i && !ack_o;
  assign widx = adr_i[9:2];

  // Channel word offset from the first channel word; [4:2] picks the channel
  logic [7:0] ch_off;
  assign ch_off = widx - 8'(CH_BASE);

  // Wishbone acknowledge: one cycle after request, dropped next cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
    end
    else
    begin
      ack_o <= cyc_i && stb_i && !ack_o;
    end
  end

  // Read data mux; unmapped words read zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dat_o <= 32'h0000_0000;
    end
    else if (cyc_i && stb_i && !ack_o)
    begin
      dat_o <= 32'h0000_0000;
      if (widx < 8'(NODES))
      begin
        dat_o <= {22'h000000, node_cfg[widx[5:0]]};
      end
      else if (widx == `IET_IDX_SRCSEL)
      begin
        dat_o <= 32'(src_sel);
      end
      else if (widx == `IET_IDX_TRAPFLAG)
      begin
        dat_o <= 32'(trap_flag);
      end
      else if (widx == `IET_IDX_EDGECFG)
      begin
        dat_o <= 32'(edge_cfg);
      end
      else if (widx == `IET_IDX_GATECFG)
      begin
        dat_o <= gate_cfg;
      end
      else if (widx == `IET_IDX_PATTERN)
      begin
        dat_o <= 32'(pattern);
      end
      else if (widx >= 8'(CH_BASE) && widx < 8'(CH_BASE + 4 * CHANS))
      begin
        unique case (widx[1:0])
          2'h0: dat_o <= 32'(ch_src[ch_off[4:2]]);
          2'h1: dat_o <= 32'(ch_dst[ch_off[4:2]]);
          2'h2: dat_o <= 32'(ch_ctl[ch_off[4:2]]);
          default: dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // External request router: edge trigger logic per input channel
  logic [3:0] rise_ev;
  logic [3:0] fall_ev;
  logic [3:0] edge_ev;
  assign rise_ev = ext_req_i & ~ext_prev;
  assign fall_ev = ~ext_req_i & ext_prev;
  always_comb
  begin
    for (int c = 0; c < 4; c++)
    begin
      edge_ev[c] = (edge_cfg[2*c] && rise_ev[c]) || (edge_cfg[2*c+1] && fall_ev[c]);
    end
  end

  // Output gate units: routing matrix mask plus pattern filter
  logic [3:0] gate_ev;
  always_comb
  begin
    for (int g = 0; g < 4; g++)
    begin
      logic [3:0] msk;
      logic hit;
      logic match;
      msk = gate_cfg[g*8 +: 4];
      hit = |(edge_ev & msk);
      match = ((ext_req_i & msk) == (pattern[g*4 +: 4] & msk));
      unique case (iet_gate_type'(gate_cfg[g*8+4 +: 2]))
        IET_GATE_PASS: gate_ev[g] = hit;
        IET_GATE_MATCH: gate_ev[g] = hit && match;
        IET_GATE_MISS: gate_ev[g] = hit && !match;
        IET_GATE_BLOCK: gate_ev[g] = 1'b0;
      endcase
    end
  end

  // Input history for edge detection
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ext_prev <= 4'h0;
      esr_prev <= 3'h0;
    end
    else
    begin
      ext_prev <= ext_req_i;
      esr_prev <= esr_pin_i;
    end
  end

  // Effective node request events: gates feed nodes 56..59, shared nodes on top
  logic [NODES-1:0] hw_ev;
  always_comb
  begin
    hw_ev = src_i;
    hw_ev[NODES-8 +: 4] = src_i[NODES-8 +: 4] | gate_ev;
    for (int k = 0; k < SHARED; k++)
    begin
      hw_ev[NODES-SHARED+k] = src_sel[k] ? alt_src_i[k] : src_i[NODES-SHARED+k];
    end
  end

  // Trap arbitration: highest set and untaken flag wins
  logic [10:0] trap_pend;
  logic trap_found;
  logic [3:0] trap_idx;
  assign trap_pend = trap_flag & ~trap_taken;
  always_comb
  begin
    trap_found = 1'b0;
    trap_idx = 4'h0;
    for (int t = 0; t < 11; t++)
    begin
      if (trap_pend[t] && (!trap_busy_o || 4'(t) > trap_prio))
      begin
        trap_found = 1'b1;
        trap_idx = 4'(t);
      end
    end
  end

  // Node arbitration: strictly above CPU level, ties to lower node
  logic node_found;
  logic [5:0] node_idx;
  logic [3:0] best_prio;
  always_comb
  begin
    node_found = 1'b0;
    node_idx = 6'h00;
    best_prio = cpu_level_i;
    for (int n = 0; n < NODES; n++)
    begin
      if (node_cfg[n][`IET_NODE_REQ_BIT] && node_cfg[n][`IET_NODE_EN_BIT]
          && node_cfg[n][3:0] > best_prio)
      begin
        node_found = 1'b1;
        node_idx = 6'(n);
        best_prio = node_cfg[n][3:0];
      end
    end
  end

  // Grant decisions taken in idle
  logic idle;
  logic grant_trap;
  logic grant_sw;
  logic grant_node;
  logic node_to_xfer;
  logic [2:0] node_chan;
  logic chan_zero;
  assign idle = (state == IET_ST_IDLE);
  assign grant_trap = idle && trap_found;
  assign grant_sw = idle && !trap_found && sw_trap_i && !trap_busy_o;
  assign grant_node = idle && !trap_found && !sw_trap_i && node_found && !trap_busy_o;
  assign node_to_xfer = node_cfg[node_idx][`IET_NODE_XFER_BIT];
  assign node_chan = node_cfg[node_idx][`IET_NODE_CHAN_LSB +: 3];
  assign chan_zero = (ch_ctl[node_chan][7:0] == 8'h00);

  // Latency in CPU clocks chosen by jump cache use
  logic [3:0] lat_load;
  assign lat_load = jump_cache_i ? 4'(`IET_LAT_CACHE - 1) : 4'(`IET_LAT_NOCACHE - 1);

  // Service sequencer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= IET_ST_IDLE;
      lat_cnt <= 4'h0;
      vector_o <= 8'h00;
      act_chan <= 3'h0;
    end
    else
    begin
      unique case (state)
        IET_ST_IDLE:
        begin
          if (grant_trap)
          begin
            state <= IET_ST_WAIT;
            lat_cnt <= 4'h0;
            vector_o <= `IET_TRAP_VEC_BASE + 8'(trap_idx);
          end
          else if (grant_sw)
          begin
            state <= IET_ST_WAIT;
            lat_cnt <= 4'h0;
            vector_o <= sw_trap_num_i;
          end
          else if (grant_node && node_to_xfer && !chan_zero)
          begin
            state <= IET_ST_STEAL;
            act_chan <= node_chan;
          end
          else if (grant_node)
          begin
            state <= IET_ST_WAIT;
            lat_cnt <= lat_load;
            vector_o <= 8'(node_idx);
          end
        end
        IET_ST_WAIT:
        begin
          if (lat_cnt == 4'h0)
          begin
            state <= IET_ST_IDLE;
          end
          else
          begin
            lat_cnt <= lat_cnt - 4'h1;
          end
        end
        IET_ST_STEAL:
        begin
          state <= IET_ST_IDLE;
        end
      endcase
    end
  end

  // CPU-facing handshakes
  assign branch_o = (state == IET_ST_WAIT) && (lat_cnt == 4'h0);
  assign cpu_stall_o = (state == IET_ST_STEAL);
  assign xfer_valid_o = (state == IET_ST_STEAL);

  // Trap service tracking; one nesting level recorded
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      trap_busy_o <= 1'b0;
      trap_prio <= 4'h0;
    end
    else if (grant_trap)
    begin
      trap_busy_o <= 1'b1;
      trap_prio <= trap_idx;
    end
    else if (trap_ret_i)
    begin
      trap_busy_o <= 1'b0;
      trap_prio <= 4'h0;
    end
  end

  // Trap flags: hardware sets win over software write-one-to-clear
  logic [10:0] trap_set;
  assign trap_set = {esr_pin_i & ~esr_prev, hw_trap_i};
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      trap_flag <= 11'h000;
      trap_taken <= 11'h000;
    end
    else
    begin
      logic [10:0] clr;
      clr = (wr_en && widx == `IET_IDX_TRAPFLAG) ? 11'(lane_merge(32'h0, dat_i, sel_i)) : 11'h000;
      trap_flag <= (trap_flag & ~clr[10:0]) | trap_set;
      trap_taken <= (trap_taken & ~clr[10:0] & ~trap_set)
                    | (grant_trap ? 11'(1) << trap_idx : 11'h000);
    end
  end

  // Router and source-select configuration registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      src_sel <= '0;
      edge_cfg <= 8'h00;
      gate_cfg <= 32'h0000_0000;
      pattern <= 16'h0000;
    end
    else if (wr_en)
    begin
      if (widx == `IET_IDX_SRCSEL)
      begin
        src_sel <= SHARED'(lane_merge(32'(src_sel), dat_i, sel_i));
      end
      if (widx == `IET_IDX_EDGECFG)
      begin
        edge_cfg <= 8'(lane_merge(32'(edge_cfg), dat_i, sel_i));
      end
      if (widx == `IET_IDX_GATECFG)
      begin
        gate_cfg <= lane_merge(gate_cfg, dat_i, sel_i);
      end
      if (widx == `IET_IDX_PATTERN)
      begin
        pattern <= 16'(lane_merge(32'(pattern), dat_i, sel_i));
      end
    end
  end

  // Node control: software writes, hardware events set, grant clears
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int n = 0; n < NODES; n++)
      begin
        node_cfg[n] <= `IET_NODE_RESET;
      end
    end
    else
    begin
      for (int n = 0; n < NODES; n++)
      begin
        logic [9:0] nv;
        nv = node_cfg[n];
        if (grant_node && node_idx == 6'(n))
        begin
          nv[`IET_NODE_REQ_BIT] = 1'b0;
        end
        if (wr_en && widx == 8'(n))
        begin
          nv = 10'(lane_merge(32'(nv), dat_i, sel_i));
        end
        if (hw_ev[n])
        begin
          nv[`IET_NODE_REQ_BIT] = 1'b1;
        end
        node_cfg[n] <= nv;
      end
    end
  end

  // Transfer channels: pointers and counter per channel
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int c = 0; c < CHANS; c++)
      begin
        ch_src[c] <= '0;
        ch_dst[c] <= '0;
        ch_ctl[c] <= 12'h000;
      end
    end
    else
    begin
      for (int c = 0; c < CHANS; c++)
      begin
        logic [AW-1:0] step;
        step = ch_ctl[c][`IET_CH_WORD_BIT] ? AW'(2) : AW'(1);
        if (state == IET_ST_STEAL && act_chan == 3'(c))
        begin
          if (ch_ctl[c][`IET_CH_INCSRC_BIT])
          begin
            ch_src[c] <= ch_src[c] + step;
          end
          if (ch_ctl[c][`IET_CH_INCDST_BIT])
          begin
            ch_dst[c] <= ch_dst[c] + step;
          end
          if (!ch_ctl[c][`IET_CH_CONT_BIT])
          begin
            ch_ctl[c][7:0] <= ch_ctl[c][7:0] - 8'h01;
          end
        end
        else if (wr_en && widx[7:2] == 6'((CH_BASE >> 2) + c))
        begin
          unique case (widx[1:0])
            2'h0: ch_src[c] <= AW'(lane_merge(32'(ch_src[c]), dat_i, sel_i));
            2'h1: ch_dst[c] <= AW'(lane_merge(32'(ch_dst[c]), dat_i, sel_i));
            2'h2: ch_ctl[c] <= 12'(lane_merge(32'(ch_ctl[c]), dat_i, sel_i));
            default: ch_ctl[c] <= ch_ctl[c];
          endcase
        end
      end
    end
  end

  // Transfer port data captured at grant
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      xfer_src_o <= '0;
      xfer_dst_o <= '0;
      xfer_word_o <= 1'b0;
    end
    else if (grant_node && node_to_xfer && !chan_zero)
    begin
      xfer_src_o <= ch_src[node_chan];
      xfer_dst_o <= ch_dst[node_chan];
      xfer_word_o <= ch_ctl[node_chan][`IET_CH_WORD_BIT];
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_node_irq;
    grant_node && !(node_to_xfer && !chan_zero) && jump_cache_i;
  endsequence

  a_steal_one_cycle: assert property (cpu_stall_o |=> !cpu_stall_o)
    else $error("transfer stole more than one cycle");
  a_irq_latency: assert property (s_node_irq |=> !branch_o [*6] ##1 branch_o)
    else $error("interrupt latency with jump cache not 7");
  a_count_dec: assert property (cpu_stall_o && !ch_ctl[act_chan][`IET_CH_CONT_BIT]
    |=> ch_ctl[$past(act_chan)][7:0] == $past(ch_ctl[act_chan][7:0]) - 8'h01)
    else $error("transfer counter not decremented");
  a_zero_count_irq: assert property (grant_node && node_to_xfer && chan_zero
    |=> !cpu_stall_o && state == IET_ST_WAIT)
    else $error("zero counter did not give an interrupt");
  a_trap_flag_set: assert property ((|hw_trap_i)
    |=> (trap_flag[7:0] & $past(hw_trap_i)) == $past(hw_trap_i))
    else $error("trap flag not set");
  a_trap_blocks: assert property (trap_busy_o |-> !grant_node ##1 !cpu_stall_o)
    else $error("node granted during trap service");
  a_sw_vector: assert property (grant_sw |=> branch_o && vector_o == $past(sw_trap_num_i))
    else $error("software trap vector wrong");
  a_grant_level: assert property (grant_node |-> node_cfg[node_idx][3:0] > cpu_level_i)
    else $error("grant not above CPU level");
  a_rise_edge: assert property (edge_cfg[0] && !ext_prev[0] && ext_req_i[0] |-> edge_ev[0])
    else $error("rising edge missed");
  a_wb_ack: assert property (ack_o |=> !ack_o)
    else $error("ack held two cycles");

endmodule
`default_nettype wire

//--- verif/iet_cpu_model.sv
// CPU core stand-in: ends each running trap service after a fixed hold time.
// Assumes trap_busy_i is the block's trap_busy_o level.
`timescale 1ns/10ps
`default_nettype none
module iet_cpu_model #(
  parameter int HOLD = 20
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Block side
  input wire logic trap_busy_i,
  output logic trap_ret_o
);
  int cnt;
  // Count busy cycles, then report one trap return
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !trap_busy_i || trap_ret_o)
    begin
      cnt <= 0;
      trap_ret_o <= 1'b0;
    end
    else
    begin
      cnt <= cnt + 1;
      trap_ret_o <= (cnt == HOLD - 1);
    end
  end
endmodule
`default_nettype wire

//--- verif/test_iet_top.sv
// Self-checking bench of the interrupt and event transfer block.
// Assumes the design's own assertions and a CPU stand-in ending traps.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, sn) \
  begin \
    samples_checked++; \
    if ((sn) !== (ex)) \
    begin \
      n_mismatch++; \
      $display("[FAIL] %s expected %0h seen %0h", nm, ex, sn); \
    end \
  end
module test_iet_top;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [9:0] adr_i = '0;
  logic [3:0] sel_i = 4'hF, alt_src_i = '0, ext_req_i = '0, cpu_level_i = '0;
  logic [31:0] dat_i = '0, dat_o;
  logic [63:0] src_i = '0;
  logic [7:0] hw_trap_i = '0, sw_trap_num_i = '0, vector_o;
  logic [2:0] esr_pin_i = '0;
  logic jump_cache_i = 1, sw_trap_i = 0, trap_ret_i, ack_o, branch_o, trap_busy_o;
  logic cpu_stall_o, xfer_valid_o, xfer_word_o, s_word, s_valid;
  logic [23:0] xfer_src_o, xfer_dst_o, s_src, s_dst;
  logic [7:0] s_vec;
  int n_mismatch = 0, samples_checked = 0, n;
  // Clock of 50 ns
  always #25 clk_i = ~clk_i;
  iet_top iet_top_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .src_i, .alt_src_i, .ext_req_i, .hw_trap_i, .esr_pin_i, .cpu_level_i,
    .jump_cache_i, .sw_trap_i, .sw_trap_num_i, .trap_ret_i, .branch_o, .vector_o,
    .trap_busy_o, .cpu_stall_o, .xfer_valid_o, .xfer_src_o, .xfer_dst_o, .xfer_word_o);
  iet_cpu_model iet_cpu_model_i (.clk_i, .rst_i, .trap_busy_i(trap_busy_o),
    .trap_ret_o(trap_ret_i));
  task automatic test_done();
    $display("Checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // One classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int k;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    for (k = 0; k < 20; k++)
    begin
      @(posedge clk_i);
      if (ack_o === 1'b1)
        break;
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
    if (k == 20)
    begin
      n_mismatch++;
      test_done();
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rchk(input string nm, input logic [9:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, '0, q);
    `CHK(nm, e, q)
  endtask
  // Count cycles from a launched pulse to a branch or a steal
  task automatic wt(input logic stl);
    for (n = 0; n < 80; n++)
    begin
      @(negedge clk_i);
      s_vec = vector_o;
      s_src = xfer_src_o;
      s_dst = xfer_dst_o;
      s_word = xfer_word_o;
      s_valid = xfer_valid_o;
      if ((stl ? cpu_stall_o : branch_o) === 1'b1)
        break;
      @(posedge clk_i);
      {src_i, alt_src_i, hw_trap_i, sw_trap_i} <= '0;
    end
    @(posedge clk_i);
    if (n == 80)
    begin
      n_mismatch++;
      test_done();
    end
  endtask
  task automatic t_nodes();
    rchk("node5_rst", 10'h014, 32'h0);
    wr(10'h014, 32'h13);
    rchk("node5", 10'h014, 32'h13);
    rchk("unmapped", 10'h3FC, 32'h0);
    src_i[5] <= 1'b1;
    wt(1'b0);
    `CHK("lat_cache", 8, n)
    `CHK("vec5", 8'h05, s_vec)
    jump_cache_i <= 1'b0;
    src_i[5] <= 1'b1;
    wt(1'b0);
    `CHK("lat_nocache", 12, n)
    jump_cache_i <= 1'b1;
  endtask
  task automatic t_prio();
    wr(10'h01C, 32'h16);
    src_i[5] <= 1'b1;
    src_i[7] <= 1'b1;
    wt(1'b0);
    `CHK("first", 8'h07, s_vec)
    wt(1'b0);
    `CHK("second", 8'h05, s_vec)
    wr(10'h01C, 32'h36);
    wt(1'b0);
    `CHK("sw_req", 8'h07, s_vec)
    cpu_level_i <= 4'h3;
    src_i[5] <= 1'b1;
    repeat (15) @(posedge clk_i);
    src_i[5] <= 1'b0;
    rchk("held", 10'h014, 32'h33);
    cpu_level_i <= 4'h0;
    wt(1'b0);
    `CHK("released", 8'h05, s_vec)
  endtask
  task automatic t_xfer();
    wr(10'h120, 32'h100);
    wr(10'h124, 32'h200);
    wr(10'h128, 32'h302);
    wr(10'h028, 32'h55);
    src_i[10] <= 1'b1;
    wt(1'b1);
    `CHK("steal_at", 2, n)
    `CHK("src0", 24'h100, s_src)
    `CHK("dst0", 24'h200, s_dst)
    `CHK("word", 1'b1, s_word)
    `CHK("valid", 1'b1, s_valid)
    @(negedge clk_i);
    `CHK("steal_len", 1'b0, cpu_stall_o)
    @(posedge clk_i);
    rchk("count1", 10'h128, 32'h301);
    src_i[10] <= 1'b1;
    wt(1'b1);
    `CHK("src1", 24'h102, s_src)
    `CHK("dst1", 24'h200, s_dst)
    rchk("count0", 10'h128, 32'h300);
    src_i[10] <= 1'b1;
    wt(1'b0);
    `CHK("zero_int", 8'h0A, s_vec)
    wr(10'h130, 32'h300);
    wr(10'h134, 32'h400);
    wr(10'h138, 32'hE01);
    wr(10'h02C, 32'hD5);
    repeat (2)
    begin
      src_i[11] <= 1'b1;
      wt(1'b1);
    end
    `CHK("ch1_src", 24'h301, s_src)
    `CHK("ch1_dst", 24'h401, s_dst)
    `CHK("byte", 1'b0, s_word)
    rchk("cont", 10'h138, 32'hE01);
  endtask
  task automatic t_traps();
    hw_trap_i[2] <= 1'b1;
    wt(1'b0);
    `CHK("trap2", 8'h82, s_vec)
    `CHK("busy", 1'b1, trap_busy_o)
    hw_trap_i[5] <= 1'b1;
    wt(1'b0);
    `CHK("nest", 8'h85, s_vec)
    src_i[5] <= 1'b1;
    wt(1'b0);
    `CHK("held_off", 1'b1, n > 12)
    `CHK("after", 8'h05, s_vec)
    rchk("flags", 10'h104, 32'h024);
    esr_pin_i[0] <= 1'b1;
    wt(1'b0);
    `CHK("pin0", 8'h88, s_vec)
    esr_pin_i[0] <= 1'b0;
    rchk("pinflag", 10'h104, 32'h124);
    wr(10'h104, 32'h7FF);
    rchk("cleared", 10'h104, 32'h0);
    repeat (30) @(posedge clk_i);
    sw_trap_num_i <= 8'h33;
    sw_trap_i <= 1'b1;
    wt(1'b0);
    `CHK("swtrap", 8'h33, s_vec)
    repeat (30) @(posedge clk_i);
  endtask
  task automatic t_router();
    wr(10'h108, 32'h1);
    wr(10'h10C, 32'h01);
    ext_req_i[0] <= 1'b1;
    repeat (3) @(posedge clk_i);
    rchk("rise", 10'h0E0, 32'h20);
    wr(10'h0E0, 32'h0);
    ext_req_i[0] <= 1'b0;
    repeat (3) @(posedge clk_i);
    rchk("fall_off", 10'h0E0, 32'h0);
    wr(10'h10C, 32'h31);
    ext_req_i[0] <= 1'b1;
    repeat (3) @(posedge clk_i);
    rchk("blocked", 10'h0E0, 32'h0);
    wr(10'h10C, 32'h11);
    ext_req_i[0] <= 1'b0;
    @(posedge clk_i);
    ext_req_i[0] <= 1'b1;
    repeat (3) @(posedge clk_i);
    rchk("match_off", 10'h0E0, 32'h0);
    wr(10'h10C, 32'h21);
    ext_req_i[0] <= 1'b0;
    @(posedge clk_i);
    ext_req_i[0] <= 1'b1;
    repeat (3) @(posedge clk_i);
    rchk("miss", 10'h0E0, 32'h20);
    wr(10'h100, 32'h1);
    alt_src_i[0] <= 1'b1;
    @(posedge clk_i);
    alt_src_i[0] <= 1'b0;
    repeat (2) @(posedge clk_i);
    rchk("alt", 10'h0F0, 32'h20);
  endtask
  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_nodes();
    t_prio();
    t_xfer();
    t_traps();
    t_router();
    test_done();
  end
endmodule
`default_nettype wire
